// ---- rtl/tmc_defs.svh ----
// Constants for the timer mode-control block
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
`define TMC_MODE_W 5
`define TMC_CNT_W 8
`define TMC_CNT_RST 8'h00
`define TMC_PER_RST 8'hFF
`define TMC_GRP_FREE 2'h0
`define TMC_GRP_ONE 2'h1
`define TMC_GRP_MONO 2'h2
`define TMC_SYNC_STAGES 2
`define TMC_EDGE_SPACING 6
`define TMC_LEVEL_HOLD 3
`define TMC_RESUME_DLY 2
`endif

// ---- rtl/tmc_pkg.sv ----
// Types shared by the timer mode-control block
package tmc_pkg;
  // Operating mode group from the upper mode bits
  typedef enum logic [1:0] {
    TMC_FREE,
    TMC_ONESHOT,
    TMC_MONO,
    TMC_RSVD
  } tmc_group_t;
  // Control inputs bundled together
  typedef struct packed {
    logic [4:0] mode;
    logic en;
    logic debug;
  } tmc_ctrl_t;
  // Status outputs bundled together
  typedef struct packed {
    logic [7:0] count;
    logic en_clear;
    logic match;
    logic running;
  } tmc_stat_t;
endpackage

// ---- rtl/tmc_sync.sv ----
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module tmc_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic din,
  output logic dout
);
  logic meta; // First stage, read only by dout
  logic next_meta;
  logic next_dout;
  // Shift only on timer clock ticks
  always_comb begin
    next_meta = meta;
    next_dout = dout;
    if (tick) begin
      next_meta = din;
      next_dout = meta;
    end
  end
  // Register stages
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule

// ---- rtl/tmc_edge.sv ----
// Edge detector on a synchronised level, one timer tick deep
`timescale 1ns/1ps
module tmc_edge (
  input wire logic clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic din,
  output logic rise,
  output logic fall
);
  logic prev; // Level one timer tick earlier
  logic next_prev;
  // Capture the level each tick
  always_comb begin
    next_prev = tick ? din : prev;
  end
  // Register the delayed copy
  always_ff @(posedge clk) begin
    if (srst) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end
  // Edges are only meaningful on a tick
  assign rise = tick & din & ~prev;
  assign fall = tick & ~din & prev;
endmodule

// ---- rtl/tmc_core.sv ----
// Mode control and counter for an 8-bit period timer with hardware limit
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_core #(
  parameter int CNT_W = `TMC_CNT_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tmr_tick,
  input wire tmc_pkg::tmc_ctrl_t ctrl,
  input wire logic ext_reset_trigger_in,
  input wire logic period_we,
  input wire logic [CNT_W-1:0] period_wdata,
  output logic [CNT_W-1:0] count_value,
  output logic [CNT_W-1:0] period_value,
  output logic en_clear,
  output logic period_match,
  output logic running
);
  import tmc_pkg::*;

  // Timing model: every timer action except a period write happens on a clk edge that carries
  // tmr_tick, so the counter, the synchronisers and the edge detector all
  // step together and stand still between ticks.
  // The enable bit and the pin are both two ticks late by the time the
  // mode logic sees them; software must allow for that latency when it
  // expects a start or stop to take effect.
  // Ticks and clk share one domain, so no handshake is needed between them.
  // Counting width is a parameter; the mode codes are fixed at five bits.

  // Decoded mode fields
  tmc_group_t grp;
  logic [2:0] sub;
  // Synchronised enable and input, plus edges
  logic en_s;
  logic ers_raw;
  logic ers_s;
  logic rise_raw;
  logic fall_raw;
  logic rise;
  logic fall;
  // Counter state
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] next_period;
  logic armed; // Set once the starting event has been seen
  logic next_armed;
  logic done; // One-shot or monostable cycle finished
  logic next_done;
  logic [1:0] hold; // Resume delay after an edge reset
  logic [1:0] next_hold;
  logic next_en_clear;
  logic next_match;
  logic next_running;
  // Combinational mode results
  logic start_ev;
  logic reset_ev;
  logic gate;
  logic valid;
  logic oneshot;
  logic edge_rst;

  // Upper bits pick the group, lower bits the variant
  assign grp = tmc_group_t'(ctrl.mode[4:3]);
  assign sub = ctrl.mode[2:0];

  // Enable bit and pin pass two timer-clock stages
  // The pin is asynchronous to clk; the enable bit gets the same stages
  // so that both reach the mode logic with equal delay.
  tmc_sync u_sync_en (
    .clk(clk),
    .srst(srst),
    .tick(tmr_tick),
    .din(ctrl.en),
    .dout(en_s)
  );
  tmc_sync u_sync_ers (
    .clk(clk),
    .srst(srst),
    .tick(tmr_tick),
    .din(ext_reset_trigger_in),
    .dout(ers_raw)
  );

  // Debug masks the trigger so no edge or level change of it takes effect
  assign ers_s = ers_raw; // Level still read; edges masked below
  tmc_edge u_edge (
    .clk(clk),
    .srst(srst),
    .tick(tmr_tick),
    .din(ers_s),
    .rise(rise_raw),
    .fall(fall_raw)
  );
  // Mask after the detector so prev keeps tracking the pin in debug
  assign rise = rise_raw & ~ctrl.debug;
  assign fall = fall_raw & ~ctrl.debug;

  // Decode start, reset and gate conditions per mode
  // start_ev arms a cycle, reset_ev clears a running count, gate lets an
  // armed count step; valid drops for reserved codes so the counter parks.
  // Levels are masked in debug as well as edges, so a level-reset mode
  // counts freely while debugging instead of freezing at zero.
  always_comb begin
    start_ev = 1'b0;
    reset_ev = 1'b0;
    gate = 1'b1;
    valid = 1'b1;
    oneshot = 1'b0;
    edge_rst = 1'b0;
    case (grp)
      // Free-running: count runs, the pin gates or resets it
      TMC_FREE: begin
        start_ev = 1'b1;
        case (sub)
          3'h0: gate = 1'b1;
          3'h1: gate = ctrl.debug | ers_s;
          3'h2: gate = ctrl.debug | ~ers_s;
          3'h3: reset_ev = rise | fall;
          3'h4: reset_ev = rise;
          3'h5: reset_ev = fall;
          3'h6: reset_ev = ~ctrl.debug & ~ers_s;
          3'h7: reset_ev = ~ctrl.debug & ers_s;
          default: valid = 1'b0;
        endcase
      end
      // One-shot: a match clears enable and parks the count
      TMC_ONESHOT: begin
        oneshot = 1'b1;
        case (sub)
          3'h0: start_ev = 1'b1;
          3'h1: start_ev = rise;
          3'h2: start_ev = fall;
          3'h3: start_ev = rise | fall;
          3'h4: begin
            start_ev = rise;
            reset_ev = rise;
            edge_rst = 1'b1;
          end
          3'h5: begin
            start_ev = fall;
            reset_ev = fall;
            edge_rst = 1'b1;
          end
          3'h6: begin
            start_ev = rise;
            reset_ev = ~ctrl.debug & ~ers_s;
          end
          3'h7: begin
            start_ev = fall;
            reset_ev = ~ctrl.debug & ers_s;
          end
          default: valid = 1'b0;
        endcase
      end
      // Monostable: stops at zero on match, enable left set except in level codes 6 and 7
      TMC_MONO: begin
        case (sub)
          3'h1: start_ev = rise;
          3'h2: start_ev = fall;
          3'h3: start_ev = rise | fall;
          3'h6: begin
            oneshot = 1'b1;
            start_ev = ~ctrl.debug & ers_s;
            reset_ev = ~ctrl.debug & ~ers_s;
          end
          3'h7: begin
            oneshot = 1'b1;
            start_ev = ~ctrl.debug & ~ers_s;
            reset_ev = ~ctrl.debug & ers_s;
          end
          default: valid = 1'b0;
        endcase
      end
      // Upper bits 11: every code reserved
      default: valid = 1'b0;
    endcase
  end

  // Counter, arming and completion control, one step per timer tick
  // Priority, highest first: stopped or reserved, finished cycle, hardware
  // reset of an armed count, free-running reset, waiting to arm, resume
  // delay, and last the normal count step.
  // Free-running modes never wait to arm: the first enabled tick already
  // counts, and a closed gate holds the count from that very first tick.
  // Period writes land between ticks too; a write that lowers the period
  // below the running count lets the counter run up to the top and wrap.
  always_comb begin
    next_count = count_value;
    next_period = period_value;
    next_armed = armed;
    next_done = done;
    next_hold = hold;
    next_en_clear = 1'b0;
    next_match = 1'b0;
    next_running = running;
    // Period loads at once, tick or not
    if (period_we) begin
      next_period = period_wdata;
    end
    if (tmr_tick) begin
      next_running = 1'b0;
      if (!valid || !en_s) begin
        // Stopped; a fresh start event is required after re-enable
        next_armed = 1'b0;
        next_done = 1'b0;
        next_hold = 2'h0;
      end else if (done) begin
        // Finished one-shot or monostable stays at zero
        next_count = '0;
        // Only an edge monostable may leave the finished state on an edge
        if (grp == TMC_MONO && !oneshot && start_ev) begin
          next_done = 1'b0;
          next_armed = 1'b1;
        end
      end else if (reset_ev && armed) begin
        // Hardware limit reset of a running count
        next_count = '0;
        if (edge_rst) begin
          next_hold = 2'(`TMC_RESUME_DLY - 1);
        end
        // Level resets disarm; a fresh start event is needed afterwards
        if (!edge_rst && grp != TMC_FREE) begin
          next_armed = 1'b0;
        end
      end else if (reset_ev && grp == TMC_FREE) begin
        // Free-running hardware limit: edge or level clears the count
        next_count = '0;
      end else if (!armed && grp != TMC_FREE) begin
        // Waiting for the start event; the arming tick itself does not
        // count, so the first step comes on the tick after the start
        if (start_ev && !(reset_ev && !edge_rst)) begin
          next_armed = 1'b1;
        end
      end else if (hold != 2'h0) begin
        // Resume delay after an edge reset; the count stays at zero
        next_hold = hold - 2'h1;
      end else if (gate) begin
        // Normal count step, or wrap and report on period match
        next_running = 1'b1;
        if (count_value == period_value) begin
          next_count = '0;
          next_match = 1'b1;
          if (oneshot) begin
            next_done = 1'b1;
            next_en_clear = 1'b1;
            next_running = 1'b0;
          end else if (grp == TMC_MONO) begin
            next_done = 1'b1;
            next_running = 1'b0;
          end
        end else begin
          next_count = count_value + 1'b1;
        end
      end
    end
  end

  // Register the counter state; reset defines count and period
  // Reset also clears the arming and resume state so a new mode starts
  // from a clean slate, whatever the previous mode left behind.
  always_ff @(posedge clk) begin
    if (srst) begin
      count_value <= `TMC_CNT_RST;
      period_value <= `TMC_PER_RST;
      armed <= 1'b0;
      done <= 1'b0;
      hold <= 2'h0;
      en_clear <= 1'b0;
      period_match <= 1'b0;
      running <= 1'b0;
    end else begin
      count_value <= next_count;
      period_value <= next_period;
      armed <= next_armed;
      done <= next_done;
      hold <= next_hold;
      en_clear <= next_en_clear;
      period_match <= next_match;
      running <= next_running;
    end
  end
endmodule

// ---- dv/tmc_asserts.sv ----
// Checker for the timer mode-control block
`timescale 1ns/1ps
module tmc_asserts
  import tmc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tmr_tick,
  input wire tmc_pkg::tmc_ctrl_t ctrl,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic [CNT_W-1:0] period_value,
  input wire logic en_clear,
  input wire logic period_match,
  input wire logic running
);
  // Ticks seen with enable high or low; saturates so it never wraps
  logic [2:0] hi_t, next_hi_t, lo_t, next_lo_t;
  // Codes that must leave the counter idle
  wire rsvd = ctrl.mode[4:3] == 2'h3 || ctrl.mode inside {5'h10, 5'h14, 5'h15};
  always_comb begin
    next_hi_t = ctrl.en ? hi_t + {2'h0, tmr_tick && hi_t != 3'h7} : 3'h0;
    next_lo_t = !ctrl.en ? lo_t + {2'h0, tmr_tick && lo_t != 3'h7} : 3'h0;
  end
  always_ff @(posedge clk) begin
    hi_t <= srst ? 3'h0 : next_hi_t;
    lo_t <= srst ? 3'h0 : next_lo_t;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  rst_vals_a: assert property ($fell(srst) |-> count_value == 8'h00 &&
    period_value == 8'hFF && !period_match && !en_clear)
    else $error("reset values wrong");
  match_zero_a: assert property (period_match |-> count_value == 8'h00 &&
    $past(count_value) == $past(period_value)) else $error("match bad");
  clr_match_a: assert property (en_clear |-> period_match)
    else $error("enable clear without match");
  clr_group_a: assert property (en_clear |->
    $past(ctrl.mode[4:3]) == 2'h1 || $past(ctrl.mode[4:1]) == 4'hB)
    else $error("enable clear in wrong mode");
  free_step_a: assert property (ctrl.mode == 5'h00 && hi_t >= 3'h4 &&
    tmr_tick |=> count_value == ($past(count_value) == $past(period_value) ?
    8'h00 : $past(count_value) + 8'h01)) else $error("free step wrong");
  stop_off_a: assert property (lo_t >= 3'h4 |->
    !running && $stable(count_value)) else $error("runs with enable low");
  hold_notick_a: assert property (!tmr_tick |=> $stable(count_value))
    else $error("count moved without tick");
  rsvd_hold_a: assert property (rsvd [*3] |=>
    $stable(count_value) && !running) else $error("reserved code ran");
  cover property (period_match && ctrl.mode == 5'h00);
  cover property (en_clear);
  cover property (rsvd && ctrl.en && tmr_tick);
endmodule
bind tmc_core tmc_asserts #(.CNT_W(CNT_W)) u_chk (.clk(clk), .srst(srst),
  .tmr_tick(tmr_tick), .ctrl(ctrl), .count_value(count_value),
  .period_value(period_value), .en_clear(en_clear),
  .period_match(period_match), .running(running));

// ---- dv/tmc_pin_model.sv ----
// Model of the logic that drives the external trigger pin
`timescale 1ns/1ps
module tmc_pin_model (
  input wire logic clk,
  input wire logic tmr_tick,
  input wire logic want,
  output logic pin
);
  // Ticks since the last pin change
  logic [2:0] gap;
  initial begin
    pin = 1'b0;
    gap = 3'h0;
  end
  // Follows want only after six ticks, so edges and levels stay legal
  always @(posedge clk) begin
    if (tmr_tick && gap != 3'h6) gap <= gap + 3'h1;
    if (tmr_tick && gap == 3'h6 && pin != want) begin
      pin <= want;
      gap <= 3'h0;
    end
  end
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the timer mode-control block
`timescale 1ns/1ps
`include "tmc_defs.svh"
module testbench;
  import tmc_pkg::*;
  logic clk, srst, tmr_tick, pin, want, period_we, en_clear;
  logic period_match, running;
  logic [7:0] period_wdata, count_value, period_value, c, p, k;
  logic [4:0] rs[4];
  tmc_ctrl_t ctrl;
  int bad_count, compares, cyc;
  integer seed;
  tmc_core i_dut (.clk(clk), .srst(srst), .tmr_tick(tmr_tick), .ctrl(ctrl),
    .ext_reset_trigger_in(pin), .period_we(period_we),
    .period_wdata(period_wdata), .count_value(count_value),
    .period_value(period_value), .en_clear(en_clear),
    .period_match(period_match), .running(running));
  tmc_pin_model i_pin (.clk(clk), .tmr_tick(tmr_tick), .want(want),
    .pin(pin));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Ticks come at random, about three clocks in four; hang guard
  always @(posedge clk) begin
    tmr_tick <= ($random(seed) & 3) != 0;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Count expected n ticks after asking for a reset edge in a resume mode:
  // the edge is seen after the sync stages plus one, then the delay runs
  function automatic logic [7:0] resumed(int n);
    return 8'(n - `TMC_SYNC_STAGES - 1 - `TMC_RESUME_DLY);
  endfunction
  // Waits n timer ticks, then lets their updates settle
  task wt(int n);
    repeat (n) begin
      @(posedge clk);
      while (tmr_tick !== 1'b1) @(posedge clk);
    end
    #1;
  endtask
  // Waits a bounded time for en_clear (s) or period_match
  task wm(bit s);
    int i;
    for (i = 0; i < 900; i++) begin
      @(posedge clk);
      #1;
      if (s ? en_clear : period_match) break;
    end
    chk("wait", 8'h01, {7'h00, i < 900});
  endtask
  task set_en(logic v);
    @(posedge clk) ctrl.en <= v;
  endtask
  task set_pin(logic v);
    @(posedge clk) want <= v;
  endtask
  // Resets the block, checks reset values, loads mode and period
  task rst(logic [4:0] m, logic [7:0] per);
    @(posedge clk);
    srst <= 1'b1;
    want <= 1'b0;
    ctrl <= '{mode: m, en: 1'b0, debug: 1'b0};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1 chk("rst_cnt", 8'h00, count_value);
    chk("rst_per", 8'hFF, period_value);
    @(posedge clk) period_we <= 1'b1;
    period_wdata <= per;
    @(posedge clk) period_we <= 1'b0;
    wt(10);
  endtask
  task tally_and_finish();
    $display("Compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    seed = 32'h740c16a0;
    srst = 1'b1;
    ctrl = '0;
    want = 1'b0;
    period_we = 1'b0;
    period_wdata = 8'h00;
    tmr_tick = 1'b0;
    cyc = 0;
    // Software gate: wraps to zero after the period value
    p = 8'h02 + 8'($random(seed) & 7);
    k = 8'h01 + 8'(($random(seed) & 32'hFF) % p);
    rst(5'h00, p);
    set_en(1'b1);
    wm(0);
    wt(k);
    chk("wrap", k, count_value);
    $display("Test free done");
    // Hardware gates, high then low sense
    for (int m = 1; m < 3; m++) begin
      rst(m[4:0], 8'hFF);
      set_en(1'b1);
      wt(10);
      chk("gate_a", m == 2, {7'h00, count_value != 0});
      set_pin(1'b1);
      wt(12);
      c = count_value;
      wt(4);
      chk("gate_b", m == 1, {7'h00, count_value != c});
      chk("gate_run", m == 1, {7'h00, running});
    end
    $display("Test gate done");
    // Rising edge reset, then the same edge masked in debug
    rst(5'h04, 8'hFF);
    set_en(1'b1);
    wt(40);
    set_pin(1'b1);
    wt(12);
    chk("edge", 8'h01, {7'h00, count_value inside {[1:11]}});
    @(posedge clk) ctrl.debug <= 1'b1;
    set_pin(1'b0);
    wt(10);
    set_pin(1'b1);
    wt(12);
    chk("debug", 8'h01, {7'h00, count_value > 8'h14});
    $display("Test edge done");
    // Software start one-shot stops at zero and asks enable clear
    rst(5'h08, p);
    set_en(1'b1);
    wm(1);
    chk("os_cnt", 8'h00, count_value);
    chk("os_match", 8'h01, {7'h00, period_match});
    set_en(1'b0);
    wt(6);
    chk("os_stop", 8'h00, count_value);
    // Edge one-shot and monostable need an edge, differ on enable clear
    for (int m = 9; m < 18; m += 8) begin
      rst(m[4:0], p);
      set_en(1'b1);
      wt(10);
      chk("no_edge", 8'h00, count_value);
      set_pin(1'b1);
      wm(0);
      chk("en_clr", m == 9, {7'h00, en_clear});
      wt(4);
      chk("stopped", 8'h00, count_value);
    end
    $display("Test oneshot done");
    // Edge start then edge reset one-shot; resumes after the delay
    rst(5'h0C, 8'hFF);
    set_en(1'b1);
    wt(10);
    chk("er_idle", 8'h00, count_value);
    set_pin(1'b1);
    wt(12);
    chk("er_start", 8'h01, {7'h00, count_value inside {[1:11]}});
    set_pin(1'b0);
    wt(10);
    set_pin(1'b1);
    wt(12);
    chk("er_resume", resumed(12), count_value);
    $display("Test resume done");
    // Level-held reset: free-running, then level-started monostable
    for (int m = 6; m < 23; m += 16) begin
      rst(m[4:0], p);
      set_en(1'b1);
      wt(10);
      chk("lvl_held", 8'h00, count_value);
      set_pin(1'b1);
      wt(3 + `TMC_SYNC_STAGES);
      chk("lvl_run", 8'h01, {7'h00, count_value != 0});
      set_pin(1'b0);
      wt(8);
      chk("lvl_reset", 8'h00, count_value);
    end
    $display("Test level done");
    // Reserved codes leave the counter idle
    rs = '{5'h10, 5'h14, 5'h15, 5'h18};
    rs[3] = rs[3] | 5'($random(seed) & 7);
    foreach (rs[i]) begin
      rst(rs[i], 8'h03);
      set_en(1'b1);
      wt(8);
      chk("rsvd", 8'h00, count_value);
    end
    $display("Test reserved done");
    tally_and_finish();
  end
endmodule
